/* File: rtl/sram_host.sv */
// Host controller driving an asynchronous 128K x 8 static memory
`timescale 1ns/1ps
module sram_host (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr,
	input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata,
	input wire logic retain_req,
	input wire logic retain_via_high,
	output logic req_ready,
	output logic rd_valid,
	output logic [sram_host_pkg::DATA_W-1:0] rd_data,
	output logic retaining,
	output logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
	output logic mem_addr_oe,
	input wire logic [sram_host_pkg::DATA_W-1:0] mem_data_i,
	output logic [sram_host_pkg::DATA_W-1:0] mem_data_o,
	output logic mem_data_oe,
	output logic select_low_active_n,
	output logic select_low_active_oe,
	output logic select_high_active,
	output logic write_strobe_n,
	output logic output_gate_n,
	output logic ctrl_oe
);
	// ==========================================================
	// Pin input synchroniser
	// ==========================================================
	logic [sram_host_pkg::DATA_W-1:0] din_meta_reg, din_meta_next;
	logic [sram_host_pkg::DATA_W-1:0] din_sync_reg, din_sync_next;
	always_comb begin
		din_meta_next = mem_data_i;
		din_sync_next = din_meta_reg;
	end
	always_ff @(posedge mclk) begin
		din_meta_reg <= din_meta_next;
		din_sync_reg <= din_sync_next;
	end
	// ==========================================================
	// Cycle sequencer
	// ==========================================================
	sram_host_pkg::host_state_e state_reg, state_next;
	logic [sram_host_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic write_reg, write_next;
	logic via_high_reg, via_high_next;
	logic [sram_host_pkg::ADDR_W-1:0] addr_reg, addr_next;
	logic [sram_host_pkg::DATA_W-1:0] wdata_reg, wdata_next;
	logic [sram_host_pkg::DATA_W-1:0] rdata_reg, rdata_next;
	logic ready_reg, ready_next;
	logic rvalid_reg, rvalid_next;
	logic sel_lo_n_reg, sel_lo_n_next;
	logic sel_lo_oe_reg, sel_lo_oe_next;
	logic sel_hi_reg, sel_hi_next;
	logic wen_reg, wen_next;
	logic oen_reg, oen_next;
	logic doe_reg, doe_next;
	logic aoe_reg, aoe_next;
	logic coe_reg, coe_next;
	logic ret_reg, ret_next;
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		write_next = write_reg;
		via_high_next = via_high_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		ready_next = 1'b0;
		rvalid_next = 1'b0;
		sel_lo_n_next = 1'b1;
		sel_lo_oe_next = 1'b1;
		sel_hi_next = 1'b0;
		wen_next = 1'b1;
		oen_next = 1'b1;
		doe_next = 1'b0;
		aoe_next = 1'b1;
		coe_next = 1'b1;
		ret_next = 1'b0;
		unique case (state_reg)
		sram_host_pkg::ST_IDLE: begin
			// Address moves only here, strobe idle; selects go active on the same edge as the address
			if (retain_req) begin
				via_high_next = retain_via_high;
				state_next = sram_host_pkg::ST_RETAIN;
			end else if (req_valid) begin
				addr_next = req_addr;
				write_next = req_write;
				wdata_next = req_wdata;
				sel_lo_n_next = 1'b0;
				sel_hi_next = 1'b1;
				cnt_next = sram_host_pkg::CNT_W'(sram_host_pkg::SETUP_CYC - 1);
				state_next = req_write ? sram_host_pkg::ST_SETUP :
					sram_host_pkg::ST_READ;
				if (!req_write) begin
					oen_next = 1'b0;
					cnt_next =
						sram_host_pkg::CNT_W'(sram_host_pkg::READ_CYC - 1);
				end
			end else begin
				ready_next = 1'b1;
			end
		end
		sram_host_pkg::ST_SETUP: begin
			// Selects already active before strobe, gate held high so the memory never drives
			sel_lo_n_next = 1'b0;
			sel_hi_next = 1'b1;
			if (cnt_reg == '0) begin
				wen_next = 1'b0;
				doe_next = 1'b1;
				cnt_next = sram_host_pkg::CNT_W'(sram_host_pkg::STROBE_CYC - 1);
				state_next = sram_host_pkg::ST_STROBE;
			end else begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
		sram_host_pkg::ST_STROBE: begin
			sel_lo_n_next = 1'b0;
			sel_hi_next = 1'b1;
			wen_next = 1'b0;
			doe_next = 1'b1;
			if (cnt_reg == '0) begin
				wen_next = 1'b1;
				cnt_next =
					sram_host_pkg::CNT_W'(sram_host_pkg::RECOVER_CYC - 1);
				state_next = sram_host_pkg::ST_RECOVER;
			end else begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
		sram_host_pkg::ST_RECOVER: begin
			// Data held past strobe rise, selects released after
			doe_next = 1'b1;
			if (cnt_reg == '0) begin
				doe_next = 1'b0;
				state_next = sram_host_pkg::ST_IDLE;
				ready_next = 1'b1;
			end else begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
		sram_host_pkg::ST_READ: begin
			sel_lo_n_next = 1'b0;
			sel_hi_next = 1'b1;
			oen_next = 1'b0;
			wen_next = 1'b1;
			if (cnt_reg == '0) begin
				// Sync delay covered: read time already exceeds two cycles
				rdata_next = din_sync_reg;
				rvalid_next = 1'b1;
				sel_lo_n_next = 1'b1;
				sel_hi_next = 1'b0;
				oen_next = 1'b1;
				state_next = sram_host_pkg::ST_IDLE;
				ready_next = 1'b1;
			end else begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
		sram_host_pkg::ST_RETAIN: begin
			ret_next = 1'b1;
			aoe_next = 1'b0;
			coe_next = 1'b0;
			if (via_high_reg) begin
				sel_hi_next = 1'b0;
				sel_lo_oe_next = 1'b0;
			end else begin
				sel_lo_n_next = 1'b1;
				sel_hi_next = 1'b1;
			end
			if (!retain_req) begin
				ret_next = 1'b0;
				state_next = sram_host_pkg::ST_IDLE;
				ready_next = 1'b1;
			end
		end
		default: begin
			state_next = sram_host_pkg::ST_IDLE;
		end
		endcase
	end
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_reg <= sram_host_pkg::ST_IDLE;
			cnt_reg <= '0;
			write_reg <= 1'b0;
			via_high_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
			rdata_reg <= '0;
			ready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			sel_lo_n_reg <= 1'b1;
			sel_lo_oe_reg <= 1'b1;
			sel_hi_reg <= 1'b0;
			wen_reg <= 1'b1;
			oen_reg <= 1'b1;
			doe_reg <= 1'b0;
			aoe_reg <= 1'b1;
			coe_reg <= 1'b1;
			ret_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			write_reg <= write_next;
			via_high_reg <= via_high_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			rvalid_reg <= rvalid_next;
			sel_lo_n_reg <= sel_lo_n_next;
			sel_lo_oe_reg <= sel_lo_oe_next;
			sel_hi_reg <= sel_hi_next;
			wen_reg <= wen_next;
			oen_reg <= oen_next;
			doe_reg <= doe_next;
			aoe_reg <= aoe_next;
			coe_reg <= coe_next;
			ret_reg <= ret_next;
		end
	end
	assign req_ready = ready_reg;
	assign rd_valid = rvalid_reg;
	assign rd_data = rdata_reg;
	assign retaining = ret_reg;
	assign mem_addr = addr_reg;
	assign mem_addr_oe = aoe_reg;
	assign mem_data_o = wdata_reg;
	assign mem_data_oe = doe_reg;
	assign select_low_active_n = sel_lo_n_reg;
	assign select_low_active_oe = sel_lo_oe_reg;
	assign select_high_active = sel_hi_reg;
	assign write_strobe_n = wen_reg;
	assign output_gate_n = oen_reg;
	assign ctrl_oe = coe_reg;
endmodule // sram_host

/* File: rtl/sram_host_pkg.sv */
// Constants shared by the asynchronous static memory host controller
package sram_host_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 10;
	// Write cycle phase lengths and read time in ns, rounded up to whole cycles
	localparam int SETUP_NS = 10;
	localparam int STROBE_NS = 60;
	localparam int RECOVER_NS = 10;
	localparam int READ_NS = 150;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC =
		(STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC =
		(RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SETUP = 6'h02,
		ST_STROBE = 6'h04,
		ST_RECOVER = 6'h08,
		ST_READ = 6'h10,
		ST_RETAIN = 6'h20
	} host_state_e;
endpackage

/* File: dv/sram_host_props.sv */
// Concurrent checks on the host controller memory pins
`timescale 1ns/1ps
module sram_host_props (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_ready,
	input wire logic retain_req,
	input wire logic rd_valid,
	input wire logic retaining,
	input wire logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
	input wire logic mem_addr_oe,
	input wire logic mem_data_oe,
	input wire logic select_low_active_n,
	input wire logic select_low_active_oe,
	input wire logic select_high_active,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire logic ctrl_oe
);
	// ==========
	// Sequences
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence strobe_pulse;
		!write_strobe_n [*6] ##1 write_strobe_n;
	endsequence
	sequence taken;
		req_valid && req_ready && !retain_req;
	endsequence
	// ==========
	// Assertions
	AST_ADDR_HOLD: assert property (!write_strobe_n
		&& $past(!write_strobe_n) |-> $stable(mem_addr))
		else $error("address moved under strobe");
	AST_STROBE_WIDTH: assert property ($fell(write_strobe_n)
		|-> strobe_pulse) else $error("strobe width wrong");
	AST_SEL_FIRST: assert property ($fell(write_strobe_n)
		|-> $past(!select_low_active_n && select_high_active))
		else $error("strobe fell before selects");
	AST_BUS_WRITE_ONLY: assert property (mem_data_oe
		|-> output_gate_n && (!write_strobe_n || $past(!write_strobe_n)))
		else $error("bus driven outside write");
	AST_GATE_IN_WRITE: assert property (!write_strobe_n
		|-> output_gate_n) else $error("gate low during write");
	AST_READ_STROBE: assert property (!output_gate_n
		|-> write_strobe_n && !mem_data_oe) else $error("strobe low in read");
	AST_READ_TIME: assert property (taken ##0 !req_write
		|-> ##[16:17] rd_valid) else $error("read answer late");
	AST_WRITE_TIME: assert property (taken ##0 req_write
		|-> ##[2:3] $fell(write_strobe_n)) else $error("write strobe late");
	AST_RET_LOW: assert property (retaining
		&& select_low_active_oe |-> select_high_active
		&& select_low_active_n && !ctrl_oe && !mem_addr_oe && !mem_data_oe)
		else $error("low retention pins");
	AST_RET_HIGH: assert property (retaining
		&& !select_low_active_oe |-> !select_high_active && !ctrl_oe)
		else $error("high retention pins");
endmodule // sram_host_props

/* File: dv/sram_mem_model.sv */
// Behavioural asynchronous 128K x 8 static memory
`timescale 1ns/1ps
module sram_mem_model (
	input wire logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
	input wire logic mem_addr_oe,
	output logic [sram_host_pkg::DATA_W-1:0] mem_data_i,
	input wire logic [sram_host_pkg::DATA_W-1:0] mem_data_o,
	input wire logic mem_data_oe,
	input wire logic select_low_active_n,
	input wire logic select_low_active_oe,
	input wire logic select_high_active,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire logic ctrl_oe
);
	logic [7:0] cells [logic [16:0]];
	logic [7:0] last = 8'h00;
	logic sel, wr, rd;
	// Floated pins count as inactive, so contents survive retention
	assign sel = select_low_active_oe && !select_low_active_n
		&& select_high_active;
	assign wr = sel && ctrl_oe && !write_strobe_n;
	assign rd = sel && ctrl_oe && write_strobe_n && !output_gate_n;
	// Level store: the byte present when the overlap ends wins
	always @* if (wr && mem_data_oe && mem_addr_oe) begin
		cells[mem_addr] = mem_data_o;
	end
	// Released bus shows the inverse, never a stale copy
	always @(rd, mem_addr, wr) begin
		if (rd) last = cells.exists(mem_addr) ? cells[mem_addr] : 8'h00;
		mem_data_i = rd ? last : ~last;
	end
endmodule // sram_mem_model

/* File: dv/sram_host_tb_top.sv */
// Self-checking testbench for the static memory host controller
`timescale 1ns/1ps
module sram_host_tb_top;
	localparam int AW = sram_host_pkg::ADDR_W;
	localparam int DW = sram_host_pkg::DATA_W;
	logic mclk = 0, resetn = 0, req_valid = 0, req_write = 0;
	logic retain_req = 0, retain_via_high = 0, req_ready, rd_valid;
	logic retaining, mem_addr_oe, mem_data_oe, select_low_active_n;
	logic select_low_active_oe, select_high_active, write_strobe_n;
	logic output_gate_n, ctrl_oe;
	logic [AW-1:0] req_addr = '0, mem_addr;
	logic [DW-1:0] req_wdata = '0, rd_data, mem_data_i, mem_data_o;
	logic [DW-1:0] ref_mem [logic [AW-1:0]];
	logic [DW-1:0] exp_q [$];
	int bad_count = 0, total_checks = 0, cyc = 0;
	sram_host sram_host_i (.mclk, .resetn, .req_valid, .req_write,
		.req_addr, .req_wdata, .retain_req, .retain_via_high, .req_ready,
		.rd_valid, .rd_data, .retaining, .mem_addr, .mem_addr_oe,
		.mem_data_i, .mem_data_o, .mem_data_oe, .select_low_active_n,
		.select_low_active_oe, .select_high_active, .write_strobe_n,
		.output_gate_n, .ctrl_oe);
	sram_mem_model sram_mem_model_i (.mem_addr, .mem_addr_oe, .mem_data_i,
		.mem_data_o, .mem_data_oe, .select_low_active_n,
		.select_low_active_oe, .select_high_active, .write_strobe_n,
		.output_gate_n, .ctrl_oe);
	// ==========
	// Tasks
	task automatic check(input string n, input logic [DW-1:0] e, g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Request waits for ready seen settled, so the next edge takes it
	task automatic do_req(input logic wr, input logic [AW-1:0] a,
		input logic [DW-1:0] d);
		while (req_ready !== 1'b1) @(posedge mclk) #1;
		req_valid = 1'b1;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		@(posedge mclk) #1;
		req_valid = 1'b0;
		if (wr) ref_mem[a] = d;
		else exp_q.push_back(ref_mem.exists(a) ? ref_mem[a] : 8'h00);
	endtask
	// Requests made during retention must be ignored
	task automatic do_retain(input logic via_high);
		@(posedge mclk) #1;
		retain_via_high = via_high;
		retain_req = 1'b1;
		req_valid = 1'b1;
		req_write = 1'b1;
		req_wdata = ~req_wdata;
		for (int i = 0; i < 50 && retaining !== 1'b1; i++) @(posedge mclk) #1;
		check("retaining", 8'h01, {7'h00, retaining});
		check("high select", {7'h00, !via_high},
			{7'h00, select_high_active});
		req_valid = 1'b0;
		retain_req = 1'b0;
		$display("test retention via_high=%0d done", via_high);
	endtask
	// ==========
	// Clock, watch and sequence
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (rd_valid === 1'b1) begin
			check("rd_data", exp_q.size() ? exp_q.pop_front() : 'x,
				rd_data);
		end
		// Hang guard, well above the expected run length
		if (cyc > 6000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		logic [AW-1:0] a;
		void'($urandom(32'h5a3e));
		repeat (16) @(posedge mclk);
		#1 resetn = 1'b1;
		for (int i = 0; i < 24; i++) begin
			a = ($urandom % 4) ? AW'($urandom) : (i[0] ? '1 : '0);
			do_req(1'b0, AW'($urandom), '0);
			do_req(1'b1, a, DW'($urandom));
			do_req(1'b0, a, '0);
		end
		$display("test write_read done");
		do_retain(1'b0);
		do_req(1'b0, a, '0);
		do_retain(1'b1);
		do_req(1'b0, a, '0);
		repeat (40) @(posedge mclk);
		check("pending reads", 8'h00, DW'(exp_q.size()));
		give_verdict();
	end
endmodule // sram_host_tb_top
bind sram_host sram_host_props sram_host_props_i (.mclk, .resetn,
	.req_valid, .req_write, .req_ready, .retain_req, .rd_valid, .retaining,
	.mem_addr, .mem_addr_oe, .mem_data_oe, .select_low_active_n,
	.select_low_active_oe, .select_high_active, .write_strobe_n,
	.output_gate_n, .ctrl_oe);
